// *** rtl/ks_map_pkg.sv ***
// package for the slot key stream xor mapper: register map, field layout, slot tables and carrier types
// assumes a single 200 MHz system clock and an ahb-lite register bus
package ks_map_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int POS_W         = 12;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] IMAX_OFS   = 8'h08;

  // control register fields
  localparam int CT_BIT    = 0;
  localparam int SLOT_LSB  = 1;
  localparam int MOD_LSB   = 3;
  localparam int FMT_LSB   = 5;
  localparam int J_LSB     = 8;
  localparam int J_W       = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // status register fields
  localparam int STAT_HELD_BIT  = 16;
  localparam int STAT_VALID_BIT = 17;

  // segment layout
  localparam int A_BITS      = 40;
  localparam int SUB_PERIOD  = 80;
  localparam int SUB_DATA    = 64;

  // data bit counts, indexed by modulation combination
  localparam int HALF_BASE [4] = '{160, 240, 224, 368};
  localparam int HALF_MULT [4] = '{2, 3, 2, 3};
  localparam int FULL_UNP  [4] = '{640, 960, 704, 1088};
  localparam int DBL_UNP   [4] = '{1600, 2400, 1664, 2528};
  localparam int FULL_SGL  [4] = '{608, 928, 672, 1056};
  localparam int DBL_SGL   [4] = '{1568, 2368, 1632, 2496};

  typedef enum logic [1:0] {SLOT_HALF, SLOT_FULL, SLOT_DOUBLE, SLOT_RSVD} slot_len_t;
  typedef enum logic [1:0] {MOD_2_4, MOD_2_8, MOD_4_4, MOD_8_8} mod_combo_t;
  typedef enum logic [1:0] {FMT_UNPROT, FMT_SINGLE, FMT_MULTI, FMT_RSVD} bfmt_t;

  // one field bit on the stream; first marks a8, the first bit of a slot
  typedef struct packed {
    logic first;
    logic bit_v;
  } field_bit_t;
endpackage : ks_map_pkg

// *** rtl/slot_keystream_xor_mapper.sv ***
// slot key stream xor mapper: xors key stream segment bits onto a and b field bits of one slot
// assumes field bits arrive a8..a47 then b0 onward, and the key stream generator runs in lockstep
//
// The address map and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps

module slot_keystream_xor_mapper
  import ks_map_pkg::*;
#(
  parameter int POS_WIDTH = POS_W
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        key_valid_i,
  input  wire logic        key_bit_i,
  output logic             key_ready_o,
  input  wire logic        data_valid_i,
  input  wire field_bit_t  data_i,
  output logic             data_ready_o,
  output logic             out_valid_o,
  output field_bit_t       out_o,
  input  wire logic        out_ready_i
);
  if (POS_WIDTH < POS_W) begin : g_chk
    $error("POS_WIDTH too small for double slot segments");
  end

  typedef struct packed {
    logic [31:0]          ctrl;
    logic [POS_WIDTH-1:0] pos;
    logic                 key_held;
    logic                 key_free;
    logic                 key_bit;
    logic [1:0]           cnt;
    field_bit_t           head;
    field_bit_t           tail;
    logic                 out_valid;
    logic                 data_ready;
    logic                 wr_pend;
    logic [7:0]           wr_addr;
    logic [31:0]          hrdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  function automatic logic [POS_WIDTH-1:0] imax_f(input logic [1:0] slot, input logic [1:0] md,
                                                  input logic [1:0] fmt, input logic [J_W-1:0] j);
    int v;
    v = 0;
    case (slot)
      SLOT_HALF:   v = (fmt == FMT_SINGLE) ? 0 : HALF_BASE[md] + HALF_MULT[md] * int'(j);
      SLOT_FULL:   v = (fmt == FMT_SINGLE) ? FULL_SGL[md] : FULL_UNP[md];
      SLOT_DOUBLE: v = (fmt == FMT_SINGLE) ? DBL_SGL[md] : DBL_UNP[md];
      default:     v = 0;
    endcase
    return POS_WIDTH'(v);
  endfunction : imax_f

  logic [POS_WIDTH-1:0] imax_c;
  logic [POS_WIDTH-1:0] kss_max_c;
  logic [POS_WIDTH-1:0] p_c;
  logic [POS_WIDTH-1:0] bi_c;
  logic                 need_key_c;
  logic                 enc_c;
  logic                 in_fire_c;
  logic                 out_fire_c;
  logic                 ahb_req_c;
  field_bit_t           res_c;
  logic [31:0]          rd_c;

  always_comb begin
    st_nxt = st_r;
    // count follows the slot table; check-word format bits past it stay clear
    imax_c    = imax_f(st_r.ctrl[SLOT_LSB+:2], st_r.ctrl[MOD_LSB+:2], st_r.ctrl[FMT_LSB+:2],
                       st_r.ctrl[J_LSB+:J_W]);
    kss_max_c = imax_f(st_r.ctrl[SLOT_LSB+:2], st_r.ctrl[MOD_LSB+:2], FMT_UNPROT,
                       st_r.ctrl[J_LSB+:J_W]) + POS_WIDTH'(A_BITS);
    p_c        = data_i.first ? '0 : st_r.pos;
    bi_c       = p_c - POS_WIDTH'(A_BITS);
    need_key_c = p_c < kss_max_c;
    if (p_c < POS_WIDTH'(A_BITS)) begin
      enc_c = st_r.ctrl[CT_BIT];
    end else if (bi_c >= imax_c) begin
      enc_c = 1'b0;
    end else if (st_r.ctrl[FMT_LSB+:2] == FMT_MULTI) begin
      enc_c = (bi_c % POS_WIDTH'(SUB_PERIOD)) < POS_WIDTH'(SUB_DATA);
    end else begin
      enc_c = 1'b1;
    end
    in_fire_c  = data_valid_i && st_r.data_ready;
    out_fire_c = st_r.out_valid && out_ready_i;
    res_c.first = data_i.first;
    res_c.bit_v = data_i.bit_v ^ (enc_c & st_r.key_bit);

    // key holding slot; a key bit past the segment end is kept for the next slot
    if (in_fire_c && need_key_c) begin
      st_nxt.key_held = 1'b0;
    end
    if (!st_r.key_held && key_valid_i) begin
      st_nxt.key_held = 1'b1;
      st_nxt.key_bit  = key_bit_i;
    end
    // registered copy so key_ready_o leaves a flip-flop directly
    st_nxt.key_free = !st_nxt.key_held;
    if (in_fire_c) begin
      st_nxt.pos = (p_c == '1) ? p_c : p_c + 1'b1;
    end

    // two-entry output buffer, head always presented
    case ({in_fire_c, out_fire_c})
      2'b10: begin
        if (st_r.cnt == 2'd0) st_nxt.head = res_c;
        else st_nxt.tail = res_c;
        st_nxt.cnt = st_r.cnt + 2'd1;
      end
      2'b01: begin
        st_nxt.head = st_r.tail;
        st_nxt.cnt  = st_r.cnt - 2'd1;
      end
      2'b11: begin
        if (st_r.cnt == 2'd1) st_nxt.head = res_c;
        else begin
          st_nxt.head = st_r.tail;
          st_nxt.tail = res_c;
        end
      end
      default: st_nxt.cnt = st_r.cnt;
    endcase
    st_nxt.out_valid  = st_nxt.cnt != 2'd0;
    // a data bit is taken only with a key bit already held, so no taken bit ever stalls
    st_nxt.data_ready = (st_nxt.cnt != 2'd2) && st_nxt.key_held;

    // ahb-lite slave, zero wait states
    ahb_req_c = hsel_i && htrans_i[1] && hready_i;
    rd_c      = 32'h0000_0000;
    if (st_r.wr_pend && st_r.wr_addr == CTRL_OFS) begin
      st_nxt.ctrl = {16'h0000, hwdata_i[15:8], 1'b0, hwdata_i[6:0]};
    end
    // a read whose address phase overlaps a control write's data phase sees the new value
    case (haddr_i[7:0])
      CTRL_OFS:   rd_c = st_nxt.ctrl;
      STATUS_OFS: rd_c = {14'h0000, st_r.out_valid, st_r.key_held, 4'h0, 12'(st_r.pos)};
      IMAX_OFS:   rd_c = {20'h0_0000, 12'(imax_f(st_nxt.ctrl[SLOT_LSB+:2], st_nxt.ctrl[MOD_LSB+:2],
                                                 st_nxt.ctrl[FMT_LSB+:2], st_nxt.ctrl[J_LSB+:J_W]))};
      default:    rd_c = 32'h0000_0000;
    endcase
    st_nxt.wr_pend = ahb_req_c && hwrite_i;
    st_nxt.wr_addr = haddr_i[7:0];
    st_nxt.hrdata  = (ahb_req_c && !hwrite_i) ? rd_c : 32'h0000_0000;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_r          <= '0;
      st_r.ctrl     <= CTRL_RST;
      st_r.key_free <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hrdata_o     = st_r.hrdata;
  assign hreadyout_o  = 1'b1;
  assign hresp_o      = 1'b0;
  assign key_ready_o  = st_r.key_free;
  assign data_ready_o = st_r.data_ready;
  assign out_valid_o  = st_r.out_valid;
  assign out_o        = st_r.head;

  property p_a_field_xor;
    @(posedge clk_sys_i) disable iff (rst_i)
    (in_fire_c && p_c < POS_WIDTH'(A_BITS) && st_r.cnt == 2'd0 && !out_fire_c)
      |=> (out_o.bit_v == ($past(data_i.bit_v) ^ ($past(st_r.ctrl[CT_BIT]) & $past(st_r.key_bit))));
  endproperty
  a_a_field_xor: assert property (p_a_field_xor) else $error("a field bit wrongly ciphered");

  property p_unprot_enc;
    @(posedge clk_sys_i) disable iff (rst_i)
    (in_fire_c && st_r.ctrl[FMT_LSB+:2] == FMT_UNPROT && p_c >= POS_WIDTH'(A_BITS)) |-> (enc_c == (bi_c < imax_c));
  endproperty
  a_unprot_enc: assert property (p_unprot_enc) else $error("unprotected span wrong");

  property p_single_enc;
    @(posedge clk_sys_i) disable iff (rst_i)
    (in_fire_c && st_r.ctrl[FMT_LSB+:2] == FMT_SINGLE && st_r.ctrl[SLOT_LSB+:2] == SLOT_FULL
     && st_r.ctrl[MOD_LSB+:2] == MOD_2_4 && p_c >= POS_WIDTH'(A_BITS)) |-> (enc_c == (bi_c < 12'd608));
  endproperty
  a_single_enc: assert property (p_single_enc) else $error("single subfield span wrong");

  property p_count_sel;
    @(posedge clk_sys_i) disable iff (rst_i)
    (st_r.ctrl[SLOT_LSB+:2] == SLOT_DOUBLE && st_r.ctrl[MOD_LSB+:2] == MOD_8_8
     && st_r.ctrl[FMT_LSB+:2] == FMT_UNPROT) |-> (imax_c == 12'd2528 && kss_max_c == 12'd2568);
  endproperty
  a_count_sel: assert property (p_count_sel) else $error("encrypted count wrong");

  property p_multi_data;
    @(posedge clk_sys_i) disable iff (rst_i)
    (in_fire_c && st_r.ctrl[FMT_LSB+:2] == FMT_MULTI && p_c >= 12'd40 && p_c <= 12'd103) |-> enc_c;
  endproperty
  a_multi_data: assert property (p_multi_data) else $error("first subfield not ciphered");

  property p_multi_skip;
    @(posedge clk_sys_i) disable iff (rst_i)
    (in_fire_c && st_r.ctrl[FMT_LSB+:2] == FMT_MULTI && p_c >= 12'd104 && p_c <= 12'd119)
      |-> (!enc_c && need_key_c);
  endproperty
  a_multi_skip: assert property (p_multi_skip) else $error("check word key bits misused");

  property p_pass_through;
    @(posedge clk_sys_i) disable iff (rst_i)
    (in_fire_c && !enc_c && st_r.cnt == 2'd0 && !out_fire_c) |=> (out_o == $past(data_i));
  endproperty
  a_pass_through: assert property (p_pass_through) else $error("clear bit altered");

  property p_key_kept;
    @(posedge clk_sys_i) disable iff (rst_i)
    (in_fire_c && !need_key_c) |=> st_r.key_held;
  endproperty
  a_key_kept: assert property (p_key_kept) else $error("key bit consumed past segment");
endmodule : slot_keystream_xor_mapper

// *** testbench/ks_partner.sv ***
// key stream generator and output sink model for the xor mapper bench
// assumes the mapper takes one key bit per stream position, in order
`timescale 1ns/1ps
module ks_partner (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic slow_i,
  input  wire logic key_ready_i,
  output logic      key_valid_o,
  output logic      key_bit_o,
  output logic      out_ready_o
);
  logic [11:0] idx_r;
  logic [2:0]  tick_r;
  // segments run back to back, so index kss_max of one slot is bit 0 of the next
  assign key_bit_o = idx_r[0] ^ idx_r[2] ^ idx_r[5];
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      idx_r <= 12'h000;
      tick_r <= 3'h0;
      key_valid_o <= 1'b0;
      out_ready_o <= 1'b0;
    end else begin
      tick_r <= tick_r + 3'h1;
      if (key_valid_o && key_ready_i) idx_r <= idx_r + 12'h001;
      // an offered bit is never withdrawn before it is taken
      key_valid_o <= (key_valid_o && !key_ready_i) || !slow_i || tick_r[1];
      out_ready_o <= !slow_i || (tick_r == 3'h7);
    end
  end
endmodule : ks_partner

// *** testbench/slot_keystream_xor_mapper_tb_top.sv ***
// self-checking bench for the slot key stream xor mapper
// assumes ks_partner plays key generator and output sink
`timescale 1ns/1ps
module slot_keystream_xor_mapper_tb_top;
  import ks_map_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        hsel_i = 1'b0;
  logic [1:0]  htrans_i = 2'h0;
  logic        hwrite_i = 1'b0;
  logic [31:0] haddr_i = 32'h0000_0000;
  logic [31:0] hwdata_i = 32'h0000_0000;
  logic [31:0] hrdata_o;
  logic        hreadyout_o;
  logic        key_v, key_b, key_r, data_r, out_v, out_r;
  logic        data_valid_i = 1'b0;
  field_bit_t  data_i = '0;
  field_bit_t  out_o;
  logic        slow = 1'b0;
  logic [31:0] rd;
  logic        exp_q[$];
  int          fails = 0;
  int          checks_done = 0;
  int          kidx = 0;

  always #2.5 clk_sys_i = ~clk_sys_i;

  slot_keystream_xor_mapper DUT (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(), .key_valid_i(key_v),
    .key_bit_i(key_b), .key_ready_o(key_r), .data_valid_i(data_valid_i), .data_i(data_i),
    .data_ready_o(data_r), .out_valid_o(out_v), .out_o(out_o), .out_ready_i(out_r));
  ks_partner MODEL (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .slow_i(slow), .key_ready_i(key_r),
    .key_valid_o(key_v), .key_bit_o(key_b), .out_ready_o(out_r));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("fails=%0d checks_done=%0d", fails, checks_done);
    if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  task automatic bus_wait;
    int n;
    n = 0;
    @(posedge clk_sys_i);
    while (hreadyout_o !== 1'b1) begin
      n++;
      if (n > 50) begin
        fails++;
        stop_test;
      end
      @(posedge clk_sys_i);
    end
  endtask : bus_wait

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= {24'h00_0000, a};
    hwrite_i <= w;
    bus_wait;
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    bus_wait;
    rd = hrdata_o;
  endtask : ahb

  function automatic logic [31:0] imax_of(input logic [1:0] s, m, f, input logic [7:0] j);
    if (s == 2'h0) return (f == 2'h1) ? 32'h0 : 32'(HALF_BASE[m] + HALF_MULT[m] * j);
    if (f == 2'h1) return (s == 2'h1) ? FULL_SGL[m] : DBL_SGL[m];
    return (s == 2'h1) ? FULL_UNP[m] : DBL_UNP[m];
  endfunction : imax_of

  task automatic set_ctrl(input logic [1:0] s, m, f, input logic [7:0] j, input logic t);
    ahb(1'b1, CTRL_OFS, {16'h0000, j, 1'b0, f, m, s, t});
  endtask : set_ctrl

  // one whole segment per slot keeps the key stream in lockstep
  task automatic run_slot(input logic [1:0] s, m, f, input logic t, input logic [7:0] j);
    int n, p, w, i, kx;
    logic [31:0] im;
    logic b, enc;
    set_ctrl(s, m, f, j, t);
    im = imax_of(s, m, f, j);
    n = imax_of(s, m, 2'h0, j) + A_BITS;
    // two bits past the segment end must pass clear and leave the held key bit alone
    for (p = 0; p < n + 2; p++) begin
      b = p[1] ^ p[4] ^ p[6];
      data_valid_i <= 1'b1;
      data_i <= field_bit_t'{p == 0, b};
      w = 0;
      @(posedge clk_sys_i);
      while (data_r !== 1'b1) begin
        if (++w > 200) begin
          fails++;
          stop_test;
        end
        @(posedge clk_sys_i);
      end
      i = p - A_BITS;
      kx = kidx + p;
      enc = (p < A_BITS) ? t : (i < im && (f != 2'h2 || i % SUB_PERIOD < SUB_DATA));
      exp_q.push_back(b ^ (enc & (kx[0] ^ kx[2] ^ kx[5])));
    end
    data_valid_i <= 1'b0;
    kidx += n;
    for (w = 0; w < 300 && exp_q.size() != 0; w++) @(posedge clk_sys_i);
    check(exp_q.size(), 32'h0000_0000);
    $display("test slot %0d mod %0d fmt %0d done", s, m, f);
  endtask : run_slot

  // a stall on the sink side fills the buffer; a lost bit shows as a miscompare
  always @(posedge clk_sys_i) begin
    if (!rst_i && out_v === 1'b1 && out_r === 1'b1) begin
      if (exp_q.size() == 0) check(32'h1, 32'h0);
      else check(out_o.bit_v, exp_q.pop_front());
    end
  end

  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    ahb(1'b0, CTRL_OFS, 32'h0000_0000);
    check(rd, CTRL_RST);
    ahb(1'b1, IMAX_OFS, 32'hFFFF_FFFF);
    ahb(1'b0, IMAX_OFS, 32'h0000_0000);
    check(rd, imax_of(2'h0, 2'h0, 2'h0, 8'h00));
    ahb(1'b0, 8'h10, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    for (int s = 0; s < 3; s++)
      for (int f = 0; f < 2; f++)
        for (int m = 0; m < 4; m++) begin
          set_ctrl(2'(s), 2'(m), 2'(f), 8'h05, 1'b0);
          ahb(1'b0, IMAX_OFS, 32'h0000_0000);
          check(rd, imax_of(2'(s), 2'(m), 2'(f), 8'h05));
        end
    $display("test registers done");
    run_slot(2'h0, 2'h0, 2'h0, 1'b1, 8'h03);
    slow <= 1'b1;
    run_slot(2'h1, 2'h0, 2'h1, 1'b0, 8'h00);
    slow <= 1'b0;
    run_slot(2'h1, 2'h2, 2'h2, 1'b1, 8'h00);
    ahb(1'b0, STATUS_OFS, 32'h0000_0000);
    check(rd, (32'h0000_0001 << STAT_HELD_BIT) | 32'(FULL_UNP[2] + A_BITS + 2));
    stop_test;
  end
endmodule : slot_keystream_xor_mapper_tb_top
